// *** shared/ovp_pkg.sv ***
// Purpose: types shared by the overvoltage pick-up block
// Assumes: enum order matches the 2-bit register codes
// Notes: none
package ovp_pkg;
  typedef enum logic [1:0] {OVP_NORMAL, OVP_FSTART, OVP_FTRIP,
                            OVP_FBLOCKED} ovp_ovr_e;
  typedef enum logic [1:0] {OVP_PP, OVP_PE, OVP_AUX3, OVP_AUX4} ovp_msel_e;
  typedef logic [16:0] ovp_ratio_t;
endpackage

// *** shared/ovp_regs.svh ***
// Purpose: register map, field positions, reset values and timing counts
// Assumes: 32-bit APB, byte addresses, one aligned word per register
// Notes: stage registers repeat per stage at 12'h100 + stage * 12'h040
// Operation
// (RL1) override normal/start/trip/blocked, needs forcing permission
// (RL2) general stage settings ignore setting group selection
// (RL3) ratio magnitude/threshold computed per supervised voltage
// (RL4) pick-up when chosen count of voltages exceed
// (RL5) release below fixed 97 percent of threshold
// (RL6) one common threshold, 0.01 percent steps, 105
// (RL7) setting group switch applies live, no halt
// (RL8) blocking input sampled every program cycle
// (RL9) pick-up unblocked raises start
// (RL10) pick-up while blocked raises blocked only
// (RL11) blocking clears active start like pick-up drop
// (RL12) blocking source asserts 5 ms before trip
// (RL13) remaining time to trip published read-only
// (RL14) expected operating time published, follows timer
// (RL15) per-channel and overall ratios at 0.01 resolution
// (RL16) threshold in primary volts at 0.1 V
// (RL17) magnitude select: phase-phase, phase-earth, aux3, aux4
// (RL18) four independent stage instances
// (RL19) pick-up drops when too few channels hold
`ifndef OVP_REGS_SVH
`define OVP_REGS_SVH

`define OVP_CTRL_OFF      12'h000
`define OVP_ISTAT_OFF     12'h004
`define OVP_IMASK_OFF     12'h008
`define OVP_VTPRI_OFF     12'h00C
`define OVP_STG_PAGE      4'h1
`define OVP_S_GEN         6'h00
`define OVP_S_GRP0        6'h04
`define OVP_S_GRP1        6'h08
`define OVP_S_RA          6'h0C
`define OVP_S_RB          6'h10
`define OVP_S_RC          6'h14
`define OVP_S_RALL        6'h18
`define OVP_S_PRIM        6'h1C
`define OVP_S_EXPT        6'h20
`define OVP_S_REMT        6'h24
`define OVP_S_STAT        6'h28

`define OVP_CTRL_FORCE    0
`define OVP_CTRL_GROUP    1
`define OVP_USET_RST      16'h2904
`define OVP_USET_MIN      16'h1388
`define OVP_USET_MAX      16'h3A98
`define OVP_VTPRI_RST     32'h0000_0064
`define OVP_PCT_SCALE     23'h00_0064
`define OVP_REL_PCT       23'h00_0061
`define OVP_PRIM_DIV      48'h0000_0000_2710
`define OVP_RATIO_MAX     17'h1_E848

`define OVP_CLK_MHZ       25
`define OVP_PROG_CYCLE_US 5000
`define OVP_PROG_CYC_CNT  (`OVP_PROG_CYCLE_US * `OVP_CLK_MHZ)

`endif

// *** src/ovp_pickup.sv ***
// Purpose: pick-up, blocking and read-out logic of four overvoltage stages
// Assumes: magnitudes and blocking come from logic on pclk
// Notes: operate/release timers live outside; the operate timer's expected and remaining times are latched here
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "ovp_regs.svh"
module ovp_pickup
  import ovp_pkg::*;
#(
  parameter int PROG_CYC_CNT = `OVP_PROG_CYC_CNT,
  parameter int STAGES       = 4, // [RL18]
  parameter int W            = 16
) (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // measurement chain, units of 0.01 percent nominal
  input  wire logic [2:0][W-1:0]       meas_pp,
  input  wire logic [2:0][W-1:0]       meas_pe,
  input  wire logic [W-1:0]            meas_aux3,
  input  wire logic [W-1:0]            meas_aux4,
  // blocking matrix
  input  wire logic [STAGES-1:0]       block_in,
  // external operate timer, units of 5 ms
  input  wire logic [STAGES-1:0][19:0] exp_time,
  input  wire logic [STAGES-1:0][19:0] rem_time,
  // stage outputs, program tick and interrupt
  output logic      [STAGES-1:0]       start_o,
  output logic      [STAGES-1:0]       blocked_o,
  output logic      [STAGES-1:0]       trip_force_o,
  output logic      [STAGES-1:0]       release_o,
  output logic                         prog_tick_o,
  output logic                         irq
);

  function automatic logic [15:0] clamp_uset(input logic [15:0] v);
    if (v < `OVP_USET_MIN) return `OVP_USET_MIN;
    if (v > `OVP_USET_MAX) return `OVP_USET_MAX;
    return v;
  endfunction

  function automatic logic is_stage(input logic [11:0] a);
    return a[11:8] == `OVP_STG_PAGE && a[5:0] <= `OVP_S_STAT && a[1:0] == 2'b00;
  endfunction

  function automatic ovp_ratio_t ratio_of(input logic [W-1:0] m,
                                          input logic [15:0] u);
    logic [22:0] q;
    q = (23'(m) * `OVP_PCT_SCALE) / 23'(u);
    return (q > 23'(`OVP_RATIO_MAX)) ? `OVP_RATIO_MAX : q[16:0];
  endfunction

  // program cycle divider
  logic [31:0] div_r;
  logic        tick;
  assign tick = div_r == 32'(PROG_CYC_CNT - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_r <= 32'h0000_0000;
    else if (tick) div_r <= 32'h0000_0000;
    else div_r <= div_r + 32'h0000_0001;
  end

  // apb access
  logic        wr_en;
  logic        setup;
  logic [1:0]  ws;
  logic [5:0]  wo;
  assign pready = 1'b1;
  assign wr_en  = psel & penable & pwrite;
  assign setup  = psel & ~penable;
  assign ws     = paddr[7:6];
  assign wo     = paddr[5:0];

  // configuration
  logic [1:0]             ctrl_r;
  logic [31:0]            vtpri_r;
  logic [7:0]             mask_r;
  logic [3:0]             gen_r  [STAGES];
  logic [17:0]            grp_r  [STAGES][2];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= 2'b00;
      vtpri_r <= `OVP_VTPRI_RST;
      mask_r  <= 8'h00;
      for (int s = 0; s < STAGES; s++) begin
        gen_r[s]    <= 4'h0; // [RL1] [RL17]
        grp_r[s][0] <= {2'b00, `OVP_USET_RST}; // [RL6]
        grp_r[s][1] <= {2'b00, `OVP_USET_RST};
      end
    end else if (wr_en) begin
      if (paddr == `OVP_CTRL_OFF) ctrl_r <= pwdata[1:0];
      if (paddr == `OVP_VTPRI_OFF) vtpri_r <= pwdata;
      if (paddr == `OVP_IMASK_OFF) mask_r <= pwdata[7:0];
      if (is_stage(paddr) && 32'(ws) < STAGES) begin
        // general word kept apart from the banked groups [RL2]
        if (wo == `OVP_S_GEN) gen_r[ws] <= pwdata[3:0];
        if (wo == `OVP_S_GRP0)
          grp_r[ws][0] <= {pwdata[17:16], clamp_uset(pwdata[15:0])};
        if (wo == `OVP_S_GRP1)
          grp_r[ws][1] <= {pwdata[17:16], clamp_uset(pwdata[15:0])};
      end
    end
  end

  // per stage evaluation
  logic [2:0][W-1:0] ch     [STAGES];
  logic [15:0]       uset   [STAGES];
  logic [1:0]        need   [STAGES];
  logic [2:0]        abv_nxt[STAGES];
  logic [STAGES-1:0] pick_nxt;
  logic [STAGES-1:0] forced;
  logic [STAGES-1:0] start_nxt;
  logic [STAGES-1:0] blk_nxt;
  logic [STAGES-1:0] trip_nxt;
  logic [2:0]        above_r[STAGES];
  always_comb begin
    for (int s = 0; s < STAGES; s++) begin
      // active group taken live each cycle [RL7]
      uset[s] = grp_r[s][ctrl_r[`OVP_CTRL_GROUP]][15:0];
      need[s] = grp_r[s][ctrl_r[`OVP_CTRL_GROUP]][17:16];
      case (ovp_msel_e'(gen_r[s][1:0])) // [RL17]
        OVP_PP:   ch[s] = meas_pp;
        OVP_PE:   ch[s] = meas_pe;
        OVP_AUX3: ch[s] = {{(2*W){1'b0}}, meas_aux3};
        OVP_AUX4: ch[s] = {{(2*W){1'b0}}, meas_aux4};
        default:  ch[s] = meas_pp;
      endcase
      if (gen_r[s][1]) need[s] = 2'd0;
      for (int c = 0; c < 3; c++) begin
        // common threshold, 97 percent release [RL5] [RL6]
        if (23'(ch[s][c]) > 23'(uset[s]))
          abv_nxt[s][c] = 1'b1;
        else if (23'(ch[s][c]) * `OVP_PCT_SCALE < 23'(uset[s]) * `OVP_REL_PCT)
          abv_nxt[s][c] = 1'b0;
        else
          abv_nxt[s][c] = above_r[s][c];
      end
      // chosen count of voltages [RL4] [RL19]
      case (need[s])
        2'd0:    pick_nxt[s] = |abv_nxt[s];
        2'd1:    pick_nxt[s] = (abv_nxt[s][0] & abv_nxt[s][1]) |
                               (abv_nxt[s][1] & abv_nxt[s][2]) |
                               (abv_nxt[s][0] & abv_nxt[s][2]);
        default: pick_nxt[s] = &abv_nxt[s];
      endcase
      forced[s] = ctrl_r[`OVP_CTRL_FORCE] &&
                  ovp_ovr_e'(gen_r[s][3:2]) != OVP_NORMAL; // [RL1]
      if (forced[s]) begin
        start_nxt[s] = ovp_ovr_e'(gen_r[s][3:2]) == OVP_FSTART;
        blk_nxt[s]   = ovp_ovr_e'(gen_r[s][3:2]) == OVP_FBLOCKED;
        trip_nxt[s]  = ovp_ovr_e'(gen_r[s][3:2]) == OVP_FTRIP;
      end else begin
        start_nxt[s] = pick_nxt[s] & ~block_in[s]; // [RL9] [RL11]
        blk_nxt[s]   = pick_nxt[s] & block_in[s]; // [RL10]
        trip_nxt[s]  = 1'b0;
      end
    end
  end

  // stage state, updated once per program cycle; release pulse cleared the next clock
  logic [STAGES-1:0] pick_r;
  logic [STAGES-1:0] start_r;
  logic [STAGES-1:0] blocked_r;
  logic [STAGES-1:0] trip_r;
  logic [STAGES-1:0] rel_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pick_r    <= '0;
      start_r   <= '0;
      blocked_r <= '0;
      trip_r    <= '0;
      rel_r     <= '0;
      for (int s = 0; s < STAGES; s++) above_r[s] <= 3'b000;
    end else begin
      rel_r <= '0;
      if (tick) begin
        // block level sampled at each program cycle [RL8]
        pick_r    <= pick_nxt;
        start_r   <= start_nxt;
        blocked_r <= blk_nxt;
        trip_r    <= trip_nxt;
        rel_r     <= start_r & ~start_nxt; // [RL11]
        for (int s = 0; s < STAGES; s++) above_r[s] <= abv_nxt[s];
      end
    end
  end

  // read-outs
  ovp_ratio_t        ratio_r[STAGES][4];
  logic [31:0]       prim_r [STAGES];
  logic [19:0]       expt_r [STAGES];
  logic [19:0]       remt_r [STAGES];
  ovp_ratio_t        rc     [STAGES][3];
  ovp_ratio_t        rmax   [STAGES];
  logic [47:0]       prim_nxt[STAGES];
  always_comb begin
    for (int s = 0; s < STAGES; s++) begin
      rmax[s] = '0;
      for (int c = 0; c < 3; c++) begin
        rc[s][c] = ratio_of(ch[s][c], uset[s]); // [RL3]
        if (rc[s][c] > rmax[s]) rmax[s] = rc[s][c];
      end
      prim_nxt[s] = (48'(vtpri_r) * 48'(uset[s])) / `OVP_PRIM_DIV; // [RL16]
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < STAGES; s++) begin
        for (int c = 0; c < 4; c++) ratio_r[s][c] <= '0;
        prim_r[s] <= 32'h0000_0000;
        expt_r[s] <= 20'h0_0000;
        remt_r[s] <= 20'h0_0000;
      end
    end else if (tick) begin
      for (int s = 0; s < STAGES; s++) begin
        for (int c = 0; c < 3; c++) ratio_r[s][c] <= rc[s][c]; // [RL15]
        ratio_r[s][3] <= rmax[s];
        prim_r[s] <= prim_nxt[s][31:0];
        expt_r[s] <= exp_time[s]; // [RL14]
        remt_r[s] <= start_nxt[s] ? rem_time[s] : 20'h0_0000; // [RL13]
      end
    end
  end

  // interrupts: start and blocked rises, write one to clear
  logic [7:0] stat_r;
  logic [7:0] ev;
  always_comb begin
    ev = 8'h00;
    for (int s = 0; s < STAGES; s++) begin
      ev[s]   = tick & start_nxt[s] & ~start_r[s];
      ev[4+s] = tick & blk_nxt[s] & ~blocked_r[s];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stat_r <= 8'h00;
    else if (wr_en && paddr == `OVP_ISTAT_OFF)
      stat_r <= (stat_r & ~pwdata[7:0]) | ev;
    else stat_r <= stat_r | ev;
  end
  assign irq = |(stat_r & mask_r);

  // read data captured in the setup phase
  logic [31:0] rd_nxt;
  logic        err_nxt;
  always_comb begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (paddr == `OVP_CTRL_OFF) rd_nxt = {30'h0, ctrl_r};
    else if (paddr == `OVP_ISTAT_OFF) rd_nxt = {24'h0, stat_r};
    else if (paddr == `OVP_IMASK_OFF) rd_nxt = {24'h0, mask_r};
    else if (paddr == `OVP_VTPRI_OFF) rd_nxt = vtpri_r;
    else if (is_stage(paddr) && 32'(ws) < STAGES) begin
      case (wo)
        `OVP_S_GEN:  rd_nxt = {28'h0, gen_r[ws]};
        `OVP_S_GRP0: rd_nxt = {14'h0, grp_r[ws][0]};
        `OVP_S_GRP1: rd_nxt = {14'h0, grp_r[ws][1]};
        `OVP_S_RA:   rd_nxt = {15'h0, ratio_r[ws][0]};
        `OVP_S_RB:   rd_nxt = {15'h0, ratio_r[ws][1]};
        `OVP_S_RC:   rd_nxt = {15'h0, ratio_r[ws][2]};
        `OVP_S_RALL: rd_nxt = {15'h0, ratio_r[ws][3]};
        `OVP_S_PRIM: rd_nxt = prim_r[ws];
        `OVP_S_EXPT: rd_nxt = {12'h0, expt_r[ws]};
        `OVP_S_REMT: rd_nxt = {12'h0, remt_r[ws]};
        `OVP_S_STAT: rd_nxt = {25'h0, above_r[ws], trip_r[ws], pick_r[ws],
                               blocked_r[ws], start_r[ws]};
        default:     err_nxt = 1'b1;
      endcase
    end else err_nxt = 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
      pslverr <= err_nxt;
    end
  end

  assign start_o      = start_r;
  assign blocked_o    = blocked_r;
  assign trip_force_o = trip_r;
  assign release_o    = rel_r;
  assign prog_tick_o  = tick;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  for (genvar g = 0; g < STAGES; g++) begin : g_chk // [RL18]
    start_go_a: assert property ( // [RL9]
      tick && !forced[g] && pick_nxt[g] && !block_in[g]
      |=> start_o[g] && !blocked_o[g])
      else $error("start missing on unblocked pick-up");
    blk_only_a: assert property ( // [RL10]
      tick && !forced[g] && pick_nxt[g] && block_in[g]
      |=> blocked_o[g] && !start_o[g])
      else $error("blocked pick-up raised start");
    blk_clear_a: assert property ( // [RL11]
      tick && !forced[g] && start_o[g] && block_in[g]
      |=> !start_o[g] && release_o[g] ##1 !release_o[g])
      else $error("start not cleared by blocking");
    cycle_hold_a: assert property ( // [RL8]
      !tick |=> $stable(start_o[g]) && $stable(blocked_o[g]))
      else $error("outputs moved between program cycles");
    hyst_hold_a: assert property ( // [RL5]
      tick && above_r[g][0] &&
      23'(ch[g][0]) * `OVP_PCT_SCALE >= 23'(uset[g]) * `OVP_REL_PCT
      |=> above_r[g][0])
      else $error("channel released above 97 percent");
    force_ovr_a: assert property ( // [RL1]
      tick && ctrl_r[`OVP_CTRL_FORCE] && gen_r[g][3:2] == 2'd2
      |=> trip_force_o[g] && !start_o[g])
      else $error("forced trip not applied");
    no_force_a: assert property ( // [RL1]
      tick && !ctrl_r[`OVP_CTRL_FORCE] |=> !trip_force_o[g])
      else $error("trip forced without permission");
    ratio_pub_a: assert property ( // [RL15]
      tick |=> ratio_r[g][3] >= ratio_r[g][0] &&
      ratio_r[g][3] >= ratio_r[g][1] && ratio_r[g][3] >= ratio_r[g][2])
      else $error("overall ratio below a channel ratio");
    gen_static_a: assert property ( // [RL2]
      wr_en && paddr == `OVP_CTRL_OFF |=> $stable(gen_r[g]))
      else $error("general settings followed group switch");
    blk_excl_a: assert property ( // [RL10]
      !(start_o[g] && blocked_o[g]))
      else $error("start and blocked both high");
    rel_pulse_a: assert property ( // [RL11]
      release_o[g] |=> !release_o[g])
      else $error("release pulse longer than one cycle");
    rem_zero_a: assert property ( // [RL13]
      tick && !start_nxt[g] |=> remt_r[g] == 20'h0_0000)
      else $error("remaining time shown without start");
    exp_pub_a: assert property ( // [RL14]
      tick |=> expt_r[g] == $past(exp_time[g]))
      else $error("expected time not published");
    thr_rng_a: assert property ( // [RL6]
      uset[g] >= `OVP_USET_MIN && uset[g] <= `OVP_USET_MAX)
      else $error("threshold outside setting range");
    ovr_blk_a: assert property ( // [RL1]
      tick && forced[g] && gen_r[g][3:2] == 2'd3
      |=> blocked_o[g] && !start_o[g] && !trip_force_o[g])
      else $error("forced blocked not applied");
  end

  irq_set_a: assert property (
    ev[0] |=> stat_r[0] ##0 (irq == mask_r[0] || |(stat_r[7:1] & mask_r[7:1])))
    else $error("start event not recorded");
  w1c_clear_a: assert property (
    wr_en && paddr == `OVP_ISTAT_OFF && pwdata[0] && !ev[0] |=> !stat_r[0])
    else $error("start flag survived write one to clear");
  unmapped_err_a: assert property (
    setup && paddr[11:8] > 4'h1 |=> pslverr)
    else $error("unmapped address gave no error");

  cov_start_c: cover property (tick && start_nxt[0] && !start_r[0]);
  cov_block_c: cover property (start_o[0] && tick && block_in[0]);
  cov_force_c: cover property (forced[0] && tick);
  cov_irq_c:   cover property (irq ##1 !irq);
  cov_rel_c:   cover property (release_o[0]);

endmodule

// *** tb/ovp_meas_model.sv ***
// Purpose: behavioural measurement chain and blocking matrix
// Assumes: bench sets target levels; chain delivers them a cycle later
// Notes: operate timer read-outs are fixed values
`timescale 1ns/100ps
module ovp_meas_model #(
  parameter logic [19:0] EXP_T = 20'h0_0008,
  parameter logic [19:0] REM_T = 20'h0_0005
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // bench targets
  input  wire logic [2:0][15:0]  lvl_pp,
  input  wire logic [2:0][15:0]  lvl_pe,
  input  wire logic [15:0]       lvl_a3,
  input  wire logic [15:0]       lvl_a4,
  input  wire logic [3:0]        blk_req,
  // towards the stage logic
  output logic      [2:0][15:0]  meas_pp,
  output logic      [2:0][15:0]  meas_pe,
  output logic      [15:0]       meas_aux3,
  output logic      [15:0]       meas_aux4,
  output logic      [3:0]        block_in,
  output logic      [3:0][19:0]  exp_time,
  output logic      [3:0][19:0]  rem_time
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_pp   <= '0;
      meas_pe   <= '0;
      meas_aux3 <= '0;
      meas_aux4 <= '0;
    end else begin
      meas_pp   <= lvl_pp;
      meas_pe   <= lvl_pe;
      meas_aux3 <= lvl_a3;
      meas_aux4 <= lvl_a4;
    end
  end
  // blocking raised one clock after the request, well ahead of any operate delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_in <= '0;
    end else begin
      block_in <= blk_req;
    end
  end
  assign exp_time = {4{EXP_T}};
  assign rem_time = {4{REM_T}};
endmodule

// *** tb/tb_top.sv ***
// Purpose: self-checking bench of the overvoltage pick-up block
// Assumes: program cycle shortened to 8 clocks
// Notes: all stages see the same measurements
`timescale 1ns/100ps
`include "ovp_regs.svh"
module tb_top import ovp_pkg::*;;
  typedef struct {
    logic [1:0]  crit;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
    logic        st;
  } ovp_row_s;
  localparam logic [15:0] HI = 16'h2968;
  localparam logic [15:0] UP = 16'h2AF8;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, rel_seen = 1'b0, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rd, prdata;
  logic pready, pslverr, prog_tick_o, irq;
  logic [2:0][15:0] lvl_pp = '0, lvl_pe = '0, meas_pp, meas_pe;
  logic [15:0] lvl_a3 = '0, lvl_a4 = '0, meas_aux3, meas_aux4;
  logic [3:0] blk_req = '0, block_in, start_o, blocked_o;
  logic [3:0] trip_force_o, release_o;
  logic [3:0][19:0] exp_time, rem_time;
  int n_fail = 0, num_checks = 0;
  ovp_row_s rows [5] = '{'{2'd0, HI, 16'h0, 16'h0, 1'b1},
    '{2'd1, HI, 16'h0, 16'h0, 1'b0}, '{2'd1, HI, HI, 16'h0, 1'b1},
    '{2'd2, HI, HI, 16'h0, 1'b0}, '{2'd2, HI, HI, HI, 1'b1}};

  ovp_pickup #(.PROG_CYC_CNT(8)) u_ovp_pickup (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .meas_pp, .meas_pe, .meas_aux3, .meas_aux4, .block_in, .exp_time,
    .rem_time, .start_o, .blocked_o, .trip_force_o, .release_o,
    .prog_tick_o, .irq);
  ovp_meas_model u_ovp_meas_model (.pclk, .presetn, .lvl_pp, .lvl_pe,
    .lvl_a3, .lvl_a4, .blk_req, .meas_pp, .meas_pe, .meas_aux3,
    .meas_aux4, .block_in, .exp_time, .rem_time);

  always #20 pclk = ~pclk;
  always @(posedge pclk) if (release_o[0] === 1'b1) rel_seen <= 1'b1;

  function automatic logic [11:0] sa(input int s, input logic [5:0] off);
    return {`OVP_STG_PAGE, s[1:0], off};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) n_fail++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input string nm, input logic [11:0] a,
                      input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask

  // two program ticks, then the edge after the answer
  task automatic settle();
    int k;
    repeat (2) begin
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (prog_tick_o !== 1'b1 && k < 20);
      if (prog_tick_o !== 1'b1) n_fail++;
    end
    @(posedge pclk);
    #1;
  endtask

  task automatic conclude();
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    n_fail++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rchk("ctrl", `OVP_CTRL_OFF, 32'h0000_0000);
    rchk("gen", sa(0, `OVP_S_GEN), 32'h0000_0000);
    rchk("grp0", sa(0, `OVP_S_GRP0), 32'h0000_2904);
    rchk("vtpri", `OVP_VTPRI_OFF, 32'h0000_0064);
    rchk("prim", sa(0, `OVP_S_PRIM), 32'h0000_0069);
    wr(`OVP_IMASK_OFF, 32'h0000_0001);
    foreach (rows[i]) begin
      wr(sa(0, `OVP_S_GRP0), {14'h0, rows[i].crit, 16'h2904});
      lvl_pp <= {rows[i].c, rows[i].b, rows[i].a};
      settle();
      chk("start", start_o[0], rows[i].st);
      rchk("ratio_a", sa(0, `OVP_S_RA), rows[i].a * 100 / 10500);
      rchk("ratio_all", sa(0, `OVP_S_RALL), rows[i].a * 100 / 10500);
    end
    chk("irq", irq, 1'b1);
    apb(1'b0, `OVP_ISTAT_OFF, 32'h0000_0000);
    chk("istat", rd[0], 1'b1);
    wr(`OVP_ISTAT_OFF, 32'h0000_00FF);
    #1;
    chk("irq_clr", irq, 1'b0);
    lvl_pp <= {3{16'h283C}};
    settle();
    chk("hold", start_o[0], 1'b1);
    rel_seen <= 1'b0;
    lvl_pp <= {3{16'h2774}};
    settle();
    chk("drop", start_o[0], 1'b0);
    chk("rel_drop", rel_seen, 1'b1);
    lvl_pp <= {3{HI}};
    settle();
    chk("start2", start_o[0], 1'b1);
    rchk("exp_t", sa(0, `OVP_S_EXPT), 32'h0000_0008);
    rchk("rem_t", sa(0, `OVP_S_REMT), 32'h0000_0005);
    wr(`OVP_ISTAT_OFF, 32'h0000_00FF);
    rel_seen <= 1'b0;
    blk_req <= 4'h1;
    settle();
    chk("blk_start", start_o[0], 1'b0);
    chk("blk_blocked", blocked_o[0], 1'b1);
    chk("blk_rel", rel_seen, 1'b1);
    chk("irq_masked", irq, 1'b0);
    rchk("istat_blk", `OVP_ISTAT_OFF, 32'h0000_0010);
    lvl_pp <= '0;
    settle();
    lvl_pp <= {3{HI}};
    settle();
    chk("pu_blk_start", start_o[0], 1'b0);
    chk("pu_blk_blocked", blocked_o[0], 1'b1);
    blk_req <= 4'h0;
    lvl_pp <= '0;
    wr(sa(0, `OVP_S_GEN), 32'h0000_0008);
    settle();
    chk("no_perm", trip_force_o[0], 1'b0);
    wr(`OVP_CTRL_OFF, 32'h0000_0003);
    for (int k = 1; k < 4; k++) begin
      wr(sa(0, `OVP_S_GEN), 32'(k) << 2);
      settle();
      chk("f_start", start_o[0], 1'(k == 1));
      chk("f_trip", trip_force_o[0], 1'(k == 2));
      chk("f_blocked", blocked_o[0], 1'(k == 3));
    end
    rchk("gen_static", sa(0, `OVP_S_GEN), 32'h0000_000C);
    wr(sa(0, `OVP_S_GEN), 32'h0000_0000);
    wr(`OVP_CTRL_OFF, 32'h0000_0000);
    wr(sa(0, `OVP_S_GRP1), 32'h0000_2EE0);
    wr(sa(0, `OVP_S_GRP0), 32'h0000_2904);
    lvl_pp <= {3{UP}};
    settle();
    chk("grp0_start", start_o[0], 1'b1);
    wr(`OVP_CTRL_OFF, 32'h0000_0002);
    settle();
    chk("grp1_start", start_o[0], 1'b0);
    wr(`OVP_CTRL_OFF, 32'h0000_0000);
    lvl_pp <= '0;
    for (int m = 1; m < 4; m++) begin
      wr(sa(0, `OVP_S_GEN), 32'(m));
      lvl_pe <= (m == 1) ? {3{UP}} : '0;
      lvl_a3 <= (m == 2) ? UP : 16'h0;
      lvl_a4 <= (m == 3) ? UP : 16'h0;
      settle();
      chk("msel_start", start_o[0], 1'b1);
    end
    wr(sa(0, `OVP_S_GEN), 32'h0000_0000);
    settle();
    chk("msel_pp", start_o[0], 1'b0);
    wr(sa(1, `OVP_S_GRP0), 32'h0000_3A98);
    lvl_pp <= {3{UP}};
    settle();
    chk("stages", start_o[1:0], 2'b01);
    rchk("prim1", sa(1, `OVP_S_PRIM), 32'h0000_0096);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped_data", rd, 32'h0000_0000);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("rst_start", start_o, 4'h0);
    chk("rst_blocked", blocked_o, 4'h0);
    chk("rst_irq", irq, 1'b0);
    presetn <= 1'b1;
    rchk("rst_grp1", sa(1, `OVP_S_GRP0), 32'h0000_2904);
    conclude();
  end
endmodule
